// >>> hw/sbw_pkg.sv
// constants and types for the seat belt and key warning controller
package sbw_pkg;
   // ==========================================================
   // time base
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W = 22;
   // ==========================================================
   // warning durations, in ms and in ticks
   localparam int unsigned WARN_MS = 6000;
   localparam int unsigned PAT_OFF_MS = 24000;
   localparam int unsigned KEY_CYCLE_MS = 600;
   localparam int unsigned BELT_TONE_MS = 1000;
   localparam logic [8:0] WARN_TICKS = 9'(WARN_MS / TICK_MS);
   localparam logic [8:0] PAT_OFF_TICKS = 9'(PAT_OFF_MS / TICK_MS);
   localparam logic [8:0] KEY_CYCLE_TICKS = 9'(KEY_CYCLE_MS / TICK_MS);
   localparam logic [8:0] BELT_TONE_TICKS = 9'(BELT_TONE_MS / TICK_MS);
   localparam logic [3:0] PAT_REPEATS = 4'h a;
   // ==========================================================
   // speed thresholds in km/h
   localparam logic [7:0] SPEED_HIGH = 8'h0a;
   localparam logic [7:0] SPEED_LOW = 8'h05;
   localparam int unsigned SYNC_W = 5;
   // ==========================================================
   // seat belt states
   typedef enum logic [1:0] {
      SBW_IGN_OFF,
      SBW_BELTED,
      SBW_UNBELTED,
      SBW_PATTERN
   } sbw_state_t;
endpackage : sbw_pkg

// >>> hw/sbw_tone.sv
// buzzer tone gate: square cycle that finishes its off phase before stopping
`timescale 1ns/1ps
`default_nettype none
module sbw_tone
   import sbw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // control
   input wire logic tick,
   input wire logic request,
   input wire logic [8:0] period,
   // tone gate
   output logic tone
);
   logic active;
   logic [8:0] count;
   logic next_active;
   logic [8:0] next_count;

   always_comb
   begin
      next_active = active;
      next_count = count;
      if (!active)
      begin
         if (request)
         begin
            next_active = 1'b1;
            next_count = 9'h000;
         end
      end
      else if (tick)
      begin
         if (count == period - 9'h001)
         begin
            // only stop at the end of an off phase, no clipped tone
            next_count = 9'h000;
            next_active = request;
         end
         else
         begin
            next_count = count + 9'h001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         active <= 1'b0;
         count <= 9'h000;
      end
      else
      begin
         active <= next_active;
         count <= next_count;
      end
   end

   assign tone = active && (count < {1'b0, period[8:1]});
endmodule // sbw_tone
`default_nettype wire

// >>> hw/sbw_warning.sv
// seat belt, overspeed pattern and key-left-in warning controller
`timescale 1ns/1ps
`default_nettype none
module sbw_warning
   import sbw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // vehicle inputs, asynchronous
   input wire logic ignition_run_input,
   input wire logic driver_belted,
   input wire logic driver_door_open,
   input wire logic key_inserted,
   input wire logic alt_charging,
   // speed in km/h, same clock domain
   input wire logic [7:0] vehicle_speed,
   // outputs
   output logic driver_lamp,
   output logic buzzer,
   output logic [1:0] belt_state
);
   // ==========================================================
   // input synchronisers: 3 flops, change taken once 2 and 3 agree
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] s1, s2, s3, filt;
   logic [SYNC_W-1:0] next_filt;
   assign raw_in = {ignition_run_input, driver_belted, driver_door_open,
                    key_inserted, alt_charging};

   always_comb
   begin
      next_filt = filt;
      for (int i = 0; i < SYNC_W; i++)
      begin
         if (s2[i] == s3[i])
            next_filt[i] = s3[i];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end
      else
      begin
         s1 <= raw_in;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end

   logic ign, belted, door, key, alt;
   assign {ign, belted, door, key, alt} = filt;

   // ==========================================================
   // time base
   logic [TICK_W-1:0] div;
   logic tick;
   logic [TICK_W-1:0] next_div;
   always_comb
   begin
      next_div = div + TICK_W'(1);
      if (div == TICK_W'(TICK_CYCLES - 1))
         next_div = '0;
   end
   assign tick = (div == TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         div <= '0;
      else
         div <= next_div;
   end

   // ==========================================================
   // seat belt state machine and 6 s timers
   sbw_state_t state, next_state;
   logic alt_q, next_alt_q;
   logic [8:0] lamp_t, next_lamp_t;   // bulb check / normal flashing
   logic [8:0] alt_lt, next_alt_lt;   // alternator lamp flashing
   logic [8:0] bz_t, next_bz_t;       // bulb check / normal buzzer
   logic [8:0] alt_bt, next_alt_bt;   // alternator buzzer
   logic [8:0] pat_t, next_pat_t;
   logic [4:0] pat_n, next_pat_n;
   logic pat_on, next_pat_on;
   logic pat_drain, next_pat_drain;
   logic alt_rise;
   assign alt_rise = alt && !alt_q;

   function automatic logic [8:0] dec(input logic [8:0] v, input logic t);
      dec = (t && v != 9'h000) ? v - 9'h001 : v;
   endfunction

   always_comb
   begin
      next_state = state;
      next_alt_q = alt;
      next_lamp_t = dec(lamp_t, tick);
      next_alt_lt = dec(alt_lt, tick);
      next_bz_t = dec(bz_t, tick);
      next_alt_bt = dec(alt_bt, tick);
      next_pat_t = dec(pat_t, tick);
      next_pat_n = pat_n;
      next_pat_on = pat_on;
      next_pat_drain = pat_drain;
      // pattern phase sequencing
      if (pat_on && tick && pat_t == 9'h001)
      begin
         if (pat_drain || pat_n == 5'h00)
         begin
            next_pat_on = 1'b0;
            next_pat_drain = 1'b0;
         end
         else if (pat_n[0] == 1'b0 && pat_n != 5'h00)
         begin
            next_pat_t = PAT_OFF_TICKS;
         end
      end
      unique case (state)
         SBW_IGN_OFF:
         begin
            if (ign)
            begin
               next_lamp_t = WARN_TICKS;
               if (belted)
                  next_state = SBW_BELTED;
               else
               begin
                  next_bz_t = WARN_TICKS;
                  if (alt)
                  begin
                     next_alt_lt = WARN_TICKS;
                     next_alt_bt = WARN_TICKS;
                  end
                  next_state = SBW_UNBELTED;
               end
            end
         end
         SBW_BELTED:
         begin
            if (!ign)
            begin
               next_lamp_t = 9'h000;
               next_alt_lt = 9'h000;
               next_state = SBW_IGN_OFF;
            end
            else if (!belted)
            begin
               next_lamp_t = WARN_TICKS;
               next_bz_t = WARN_TICKS;
               next_state = SBW_UNBELTED;
            end
            else if (alt_rise)
               next_alt_lt = WARN_TICKS;
         end
         SBW_UNBELTED:
         begin
            if (!ign)
            begin
               next_lamp_t = 9'h000;
               next_alt_lt = 9'h000;
               next_alt_bt = 9'h000;
               next_bz_t = 9'h000;
               next_pat_on = 1'b0;
               next_state = SBW_IGN_OFF;
            end
            else if (belted)
            begin
               next_lamp_t = 9'h000;
               next_bz_t = 9'h000;
               next_alt_bt = 9'h000;
               next_pat_on = 1'b0;
               next_state = SBW_BELTED;
            end
            else if (vehicle_speed >= SPEED_HIGH)
            begin
               // 21 phases counted 20 down to 0, even counts are on phases;
               // a pattern still draining is simply restarted
               next_pat_on = 1'b1;
               next_pat_drain = 1'b0;
               next_pat_t = WARN_TICKS;
               next_pat_n = 5'(2 * PAT_REPEATS);
               next_state = SBW_PATTERN;
            end
            else if (alt_rise)
            begin
               next_alt_lt = WARN_TICKS;
               next_alt_bt = WARN_TICKS;
            end
         end
         SBW_PATTERN:
         begin
            if (!ign || belted)
            begin
               next_pat_on = 1'b0;
               next_pat_drain = 1'b0;
               next_lamp_t = 9'h000;
               next_bz_t = 9'h000;
               next_alt_bt = 9'h000;
               if (!ign)
                  next_alt_lt = 9'h000;
               next_state = belted && ign ? SBW_BELTED : SBW_IGN_OFF;
            end
            else if (vehicle_speed <= SPEED_LOW)
            begin
               // an on phase is allowed to run out, an off phase ends now
               if (pat_on && pat_n[0] == 1'b1)
                  next_pat_on = 1'b0;
               else
                  next_pat_drain = 1'b1;
               next_state = SBW_UNBELTED;
            end
         end
      endcase
      // phase counter advances after the state decisions
      if (pat_on && next_pat_on && tick && pat_t == 9'h001 && !pat_drain)
      begin
         next_pat_n = pat_n - 5'h01;
         if (pat_n[0] == 1'b1)
            next_pat_t = WARN_TICKS;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= SBW_IGN_OFF;
         alt_q <= 1'b0;
         lamp_t <= 9'h000;
         alt_lt <= 9'h000;
         bz_t <= 9'h000;
         alt_bt <= 9'h000;
         pat_t <= 9'h000;
         pat_n <= 5'h00;
         pat_on <= 1'b0;
         pat_drain <= 1'b0;
      end
      else
      begin
         state <= next_state;
         alt_q <= next_alt_q;
         lamp_t <= next_lamp_t;
         alt_lt <= next_alt_lt;
         bz_t <= next_bz_t;
         alt_bt <= next_alt_bt;
         pat_t <= next_pat_t;
         pat_n <= next_pat_n;
         pat_on <= next_pat_on;
         pat_drain <= next_pat_drain;
      end
   end

   // ==========================================================
   // outputs
   logic pat_sound;  // pattern on phase: even remaining count is on
   assign pat_sound = pat_on && (pat_n[0] == 1'b0 || pat_drain);
   logic belt_req, speed_req, key_req;
   assign belt_req = bz_t != 9'h000 || alt_bt != 9'h000;
   assign speed_req = pat_sound;
   assign key_req = key && door && !ign;

   logic belt_tone, speed_tone, key_tone;
   sbw_tone u_belt_tone (.sys_clk(sys_clk), .rstn(rstn), .tick(tick),
      .request(belt_req), .period(BELT_TONE_TICKS), .tone(belt_tone));
   sbw_tone u_speed_tone (.sys_clk(sys_clk), .rstn(rstn), .tick(tick),
      .request(speed_req && !belt_req), .period(BELT_TONE_TICKS),
      .tone(speed_tone));
   sbw_tone u_key_tone (.sys_clk(sys_clk), .rstn(rstn), .tick(tick),
      .request(key_req && !belt_req && !speed_req),
      .period(KEY_CYCLE_TICKS), .tone(key_tone));

   logic next_lamp, next_buzzer;
   logic blink;
   assign blink = div[TICK_W-1];
   always_comb
   begin
      next_lamp = pat_sound ||
         ((lamp_t != 9'h000 || alt_lt != 9'h000) && blink);
      // fixed priority: belt over overspeed over key
      if (belt_tone)
         next_buzzer = 1'b1;
      else if (speed_tone)
         next_buzzer = !belt_req;
      else
         next_buzzer = key_tone && !belt_req && !speed_req;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         driver_lamp <= 1'b0;
         buzzer <= 1'b0;
         belt_state <= 2'h0;
      end
      else
      begin
         driver_lamp <= next_lamp;
         buzzer <= next_buzzer;
         belt_state <= 2'(state);
      end
   end
endmodule // sbw_warning
`default_nettype wire

// >>> tb/sbw_warning_checker.sv
// port assertions for the seat belt and key warning controller
`timescale 1ns/1ps
`default_nettype none
module sbw_warning_checker
   import sbw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // vehicle inputs
   input wire logic ignition_run_input,
   input wire logic driver_belted,
   input wire logic driver_door_open,
   input wire logic key_inserted,
   input wire logic alt_charging,
   input wire logic [7:0] vehicle_speed,
   // outputs
   input wire logic driver_lamp,
   input wire logic buzzer,
   input wire logic [1:0] belt_state
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // state machine
   // windows of 8 cover the input synchroniser before a reaction is due
   chk_ign_off_state: assert property (
      !ignition_run_input [*8] |-> ##[0:4] belt_state == 2'h0)
      else $error("state not off after ignition off");
   chk_belted_state: assert property (
      (ignition_run_input && driver_belted) [*8]
      |-> ##[0:4] belt_state == 2'h1)
      else $error("state not belted");
   chk_unbelted_state: assert property (
      (ignition_run_input && !driver_belted && belt_state != 2'h3
       && vehicle_speed < SPEED_HIGH) [*8] |-> ##[0:4] belt_state == 2'h2)
      else $error("state not unbelted");
   chk_pattern_entry: assert property (
      (ignition_run_input && !driver_belted
       && vehicle_speed >= SPEED_HIGH) [*8] |-> ##[0:4] belt_state == 2'h3)
      else $error("pattern not entered at speed");
   chk_pattern_source: assert property (
      belt_state inside {2'h0, 2'h1} |=> belt_state != 2'h3)
      else $error("pattern entered from wrong state");
   chk_pattern_hold: assert property (
      belt_state == 2'h3 && ignition_run_input && !driver_belted
      && vehicle_speed > SPEED_LOW |=> belt_state == 2'h3)
      else $error("pattern left above low speed");
   // ==========================================================
   // lamp and buzzer
   chk_lamp_off_idle: assert property (
      belt_state == 2'h0 [*3] |-> !driver_lamp)
      else $error("lamp lit with ignition off");
   chk_buzzer_quiet_off: assert property (
      (belt_state == 2'h0 && !key_inserted) [*8] |-> !$rose(buzzer))
      else $error("buzzer started without key");
   chk_key_quiet_run: assert property (
      belt_state == 2'h1 [*8] |-> !$rose(buzzer))
      else $error("buzzer started while belted");
   cov_pattern: cover property (belt_state == 2'h3);
   cov_belted: cover property (belt_state == 2'h1);
   cov_unbelted: cover property (belt_state == 2'h2);
endmodule // sbw_warning_checker

bind sbw_warning sbw_warning_checker chk_u (
   .sys_clk(sys_clk), .rstn(rstn),
   .ignition_run_input(ignition_run_input),
   .driver_belted(driver_belted), .driver_door_open(driver_door_open),
   .key_inserted(key_inserted), .alt_charging(alt_charging),
   .vehicle_speed(vehicle_speed), .driver_lamp(driver_lamp),
   .buzzer(buzzer), .belt_state(belt_state));
`default_nettype wire

// >>> tb/sbw_vehicle.sv
// vehicle side model: switches, speed sensor and the two loads
`timescale 1ns/1ps
`default_nettype none
module sbw_vehicle (
   // clock
   input wire logic sys_clk,
   // switches and sensor
   output logic ignition_run_input,
   output logic driver_belted,
   output logic driver_door_open,
   output logic key_inserted,
   output logic alt_charging,
   output logic [7:0] vehicle_speed,
   // loads
   input wire logic driver_lamp,
   input wire logic buzzer
);
   int unsigned lamp_cycles = 0;
   int unsigned buzz_cycles = 0;
   initial
   begin
      {ignition_run_input, driver_belted, driver_door_open} = 3'h0;
      {key_inserted, alt_charging} = 2'h0;
      vehicle_speed = 8'h00;
   end
   // loads only accumulate on-time, as a real bulb or sounder would
   always @(posedge sys_clk)
   begin
      lamp_cycles <= lamp_cycles + 32'(driver_lamp === 1'b1);
      buzz_cycles <= buzz_cycles + 32'(buzzer === 1'b1);
   end
   task automatic drive(input logic ign, belt, door, key, alt,
                        input logic [7:0] spd);
      @(posedge sys_clk);
      ignition_run_input <= ign;
      driver_belted <= belt;
      driver_door_open <= door;
      key_inserted <= key;
      alt_charging <= alt;
      vehicle_speed <= spd;
   endtask
endmodule // sbw_vehicle
`default_nettype wire

// >>> tb/sbw_warning_test.sv
// self-checking bench for the seat belt and key warning controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module sbw_warning_test;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   wire logic ign, belt, door, key, alt, lamp, buzz;
   wire logic [7:0] speed;
   wire logic [1:0] state;
   int fail_count = 0;
   int n_compared = 0;

   always #20 sys_clk = ~sys_clk;

   sbw_vehicle veh_u (.sys_clk(sys_clk), .ignition_run_input(ign),
      .driver_belted(belt), .driver_door_open(door), .key_inserted(key),
      .alt_charging(alt), .vehicle_speed(speed), .driver_lamp(lamp),
      .buzzer(buzz));
   sbw_warning dut_u (.sys_clk(sys_clk), .rstn(rstn),
      .ignition_run_input(ign), .driver_belted(belt),
      .driver_door_open(door), .key_inserted(key), .alt_charging(alt),
      .vehicle_speed(speed), .driver_lamp(lamp), .buzzer(buzz),
      .belt_state(state));

   task automatic summarize;
      $display("mismatches %0d compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // 12 cycles covers the synchroniser plus two state hops
   task automatic step(input logic i, b, d, k, a, input logic [7:0] s,
                       input logic [1:0] exp);
      veh_u.drive(i, b, d, k, a, s);
      repeat (12) @(posedge sys_clk);
      #1;
      `CHK(state, exp)
   endtask

   // mid-run reset with the switches set inside it, so they arrive together
   task automatic reset_to(input logic i, b, d, k, a, input logic [7:0] s);
      @(posedge sys_clk);
      rstn <= 1'b0;
      veh_u.drive(i, b, d, k, a, s);
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
   endtask

   // ==========================================================
   // sequence
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
      `CHK({state, lamp, buzz}, 4'h0)
      step(1, 0, 0, 0, 0, 8'h00, 2'h2);
      `CHK(buzz, 1'b1)
      step(1, 0, 0, 0, 1, 8'h00, 2'h2);
      step(1, 0, 0, 0, 1, 8'h09, 2'h2);
      step(1, 0, 0, 0, 1, 8'h0a, 2'h3);
      `CHK(lamp, 1'b1)
      step(1, 0, 0, 0, 1, 8'h06, 2'h3);
      step(1, 0, 0, 0, 1, 8'h05, 2'h2);
      `CHK(lamp, 1'b1)
      step(1, 0, 0, 0, 1, 8'h0a, 2'h3);
      step(1, 1, 0, 0, 1, 8'h06, 2'h1);
      step(1, 0, 0, 0, 0, 8'h0c, 2'h3);
      step(0, 0, 1, 1, 0, 8'h0c, 2'h0);
      `CHK(lamp, 1'b0)
      step(0, 0, 0, 1, 0, 8'h00, 2'h0);
      step(1, 1, 1, 1, 0, 8'h00, 2'h1);
      step(1, 0, 1, 1, 0, 8'h00, 2'h2);
      step(1, 1, 0, 0, 0, 8'h00, 2'h1);
      step(1, 0, 0, 0, 0, 8'h00, 2'h2);
      step(0, 0, 0, 0, 0, 8'h00, 2'h0);
      reset_to(0, 0, 1, 1, 0, 8'h00);
      step(0, 0, 1, 1, 0, 8'h00, 2'h0);
      `CHK(buzz, 1'b1)
      reset_to(1, 1, 1, 1, 0, 8'h00);
      step(1, 1, 1, 1, 0, 8'h00, 2'h1);
      `CHK(buzz, 1'b0)
      `CHK(veh_u.lamp_cycles != 0, 1'b1)
      summarize();
   end

   // the sequence needs about 260 cycles; 2000 means a hang
   initial
   begin
      repeat (2000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end
endmodule // sbw_warning_test
`default_nettype wire
